// ### rtl/module_mgmt_control_timing.v
// Sideband control, flags, masks and two-wire slave of the module
`timescale 1ns/100ps
`include "module_mgmt_map.vh"

// Functional notes
// RULE_01: Fully functional within 2000 ms after reset
// RULE_02: Reset pin low over 2 us resets
// RULE_03: Serial bus answers after init time
// RULE_04: Clear data-not-ready, assert interrupt when ready
// RULE_05: Low-power pin reduces power within 100 us
// RULE_06: Interrupt condition drives interrupt low promptly
// RULE_07: Read clears flags; interrupt released afterwards
// RULE_08: Loss condition sets flag and interrupt
// RULE_09: Other conditions set flag and interrupt
// RULE_10: Mask set inhibits flag's interrupt
// RULE_11: Mask cleared resumes flag's interrupt
// RULE_12: Select asserted enables serial responses
// RULE_13: Select deasserted disables serial responses
// RULE_14: Power-down bit enters low power
// RULE_15: Power-down cleared restores full function
// RULE_16: Write and read effects apply at stop
// RULE_17: Respond at seven-bit address 1010000
// RULE_18: Interrupt held while unmasked flag set
module module_mgmt_control_timing #(
  parameter [31:0] INIT_CYCLES  = `INIT_CYCLES,
  parameter [7:0]  IDENT_VALUE  = 8'h5A  // Arbitrary identifier value
) (
  input  wire       ref_clk_i,
  input  wire       reset_n_i,
  input  wire       module_reset_n_i,
  input  wire       module_select_n_i,
  input  wire       low_power_request_pin_i,
  input  wire [7:0] flag_condition_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  output reg        interrupt_out_n_o,
  output reg        low_power_o,
  output reg        ready_o
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_PTR  = 3'd2;
  localparam [2:0] ST_WR   = 3'd3;
  localparam [2:0] ST_RD   = 3'd4;
  localparam [31:0] RESET_MIN_W = `RESET_MIN_CYCLES;
  localparam [15:0] RESET_MIN   = RESET_MIN_W[15:0];

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  reg  [1:0]  rst_s_r;
  reg  [1:0]  sel_s_r;
  reg  [1:0]  lp_s_r;
  reg  [1:0]  scl_s_r;
  reg  [1:0]  sda_s_r;
  reg         scl_d_r;
  reg         sda_d_r;

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s_r <= 2'b11;
      sel_s_r <= 2'b11;
      lp_s_r  <= 2'b00;
      scl_s_r <= 2'b11;
      sda_s_r <= 2'b11;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      rst_s_r <= {rst_s_r[0], module_reset_n_i};
      sel_s_r <= {sel_s_r[0], module_select_n_i};
      lp_s_r  <= {lp_s_r[0], low_power_request_pin_i};
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  wire scl_rise_w = scl_s_r[1] & ~scl_d_r;
  wire scl_fall_w = ~scl_s_r[1] & scl_d_r;
  wire start_w    = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
  wire stop_w     = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

  //////////////////////////////////////////////////////////////////////////////
  // Reset pulse qualification and initialisation timer
  reg  [15:0] low_cnt_r;
  reg         held_r;
  reg  [31:0] init_cnt_r;
  wire        soft_rst_w = held_r;

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_cnt_r  <= 16'h0000;
      held_r     <= 1'b0;
      init_cnt_r <= 32'h0000_0000;
      ready_o    <= 1'b0;
    end else begin
      if (rst_s_r[1]) begin
        low_cnt_r <= 16'h0000;
        held_r    <= 1'b0;
      end else if (low_cnt_r < RESET_MIN) begin
        low_cnt_r <= low_cnt_r + 16'h0001;
      end else begin
        held_r <= 1'b1;  // Only pulses longer than the minimum count [RULE_02]
      end
      if (soft_rst_w) begin
        init_cnt_r <= 32'h0000_0000;
        ready_o    <= 1'b0;
      end else if (init_cnt_r < INIT_CYCLES - 32'h0000_0001) begin
        init_cnt_r <= init_cnt_r + 32'h0000_0001;
      end else begin
        ready_o <= 1'b1;  // Timer restarts from reset release edge [RULE_01]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flags, masks, control and interrupt
  reg  [7:0]  flags_r;
  reg  [7:0]  mask_r;
  reg  [7:0]  ctrl_r;
  reg         init_flag_r;
  reg         ready_d_r;
  reg  [7:0]  clr_pend_r;
  reg         init_clr_pend_r;
  reg         mask_wr_pend_r;
  reg  [7:0]  mask_wr_val_r;
  reg         ctrl_wr_pend_r;
  reg  [7:0]  ctrl_wr_val_r;
  wire        commit_w = stop_w;
  wire [7:0]  flag_clr_w = commit_w ? clr_pend_r : 8'h00;

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_r     <= `FLAGS_RESET;
      mask_r      <= `MASK_RESET;
      ctrl_r      <= `CTRL_RESET;
      init_flag_r <= 1'b0;
      ready_d_r   <= 1'b0;
    end else if (soft_rst_w) begin
      flags_r     <= `FLAGS_RESET;
      mask_r      <= `MASK_RESET;
      ctrl_r      <= `CTRL_RESET;
      init_flag_r <= 1'b0;
      ready_d_r   <= 1'b0;
    end else begin
      ready_d_r <= ready_o;
      // Set wins over a clear in the same cycle [RULE_07] [RULE_08] [RULE_09]
      flags_r <= (flags_r & ~flag_clr_w) | (ready_o ? flag_condition_i : 8'h00);
      if (ready_o & ~ready_d_r)
        init_flag_r <= 1'b1;  // Readiness raises the interrupt [RULE_04]
      else if (commit_w & init_clr_pend_r)
        init_flag_r <= 1'b0;
      if (commit_w & mask_wr_pend_r)
        mask_r <= mask_wr_val_r;  // [RULE_10] [RULE_11] [RULE_16]
      if (commit_w & ctrl_wr_pend_r)
        ctrl_r <= ctrl_wr_val_r;  // [RULE_16]
    end
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      interrupt_out_n_o <= 1'b1;
      low_power_o       <= 1'b0;
    end else begin
      // Held low while any unmasked flag stays set [RULE_06] [RULE_18]
      interrupt_out_n_o <= ~(|(flags_r & ~mask_r) | init_flag_r);
      // Software override selects power-set bit, else the pin [RULE_05] [RULE_14] [RULE_15]
      low_power_o <= ctrl_r[`CTRL_OVERRIDE_BIT] ? ctrl_r[`CTRL_POWER_SET_BIT] : lp_s_r[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two-wire serial slave
  reg  [2:0]  state_r;
  reg  [3:0]  cnt_r;
  reg  [7:0]  sh_r;
  reg  [7:0]  tx_r;
  reg  [7:0]  ptr_r;
  reg         nack_r;
  reg  [7:0]  rd_data;

  always @* begin
    case (ptr_r)
      `OFS_IDENT:   rd_data = IDENT_VALUE;
      `OFS_STATUS:  rd_data = {7'h00, ~ready_o} << `STATUS_DNR_BIT;
      `OFS_FLAGS:   rd_data = flags_r;
      `OFS_CONTROL: rd_data = ctrl_r;
      `OFS_MASK:    rd_data = mask_r;
      default:      rd_data = 8'h00;
    endcase
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r         <= ST_IDLE;
      cnt_r           <= 4'h0;
      sh_r            <= 8'h00;
      tx_r            <= 8'h00;
      ptr_r           <= 8'h00;
      nack_r          <= 1'b1;
      sda_o           <= 1'b0;
      sda_oe_o        <= 1'b0;
      clr_pend_r      <= 8'h00;
      init_clr_pend_r <= 1'b0;
      mask_wr_pend_r  <= 1'b0;
      mask_wr_val_r   <= 8'h00;
      ctrl_wr_pend_r  <= 1'b0;
      ctrl_wr_val_r   <= 8'h00;
    end else begin
      sda_o <= 1'b0;
      if (stop_w | soft_rst_w | sel_s_r[1]) begin
        state_r         <= ST_IDLE;  // Pending effects commit here; deselect aborts [RULE_16] [RULE_13]
        sda_oe_o        <= 1'b0;
        clr_pend_r      <= 8'h00;
        init_clr_pend_r <= 1'b0;
        mask_wr_pend_r  <= 1'b0;
        ctrl_wr_pend_r  <= 1'b0;
      end else if (start_w) begin
        state_r  <= ST_ADDR;
        cnt_r    <= 4'hF;  // Skips the clock fall that closes the start
        sda_oe_o <= 1'b0;
      end else if (state_r != ST_IDLE) begin
        if (scl_rise_w) begin
          if (cnt_r == 4'h8)
            nack_r <= sda_s_r[1];
          else
            sh_r <= {sh_r[6:0], sda_s_r[1]};
        end else if (scl_fall_w) begin
          if (cnt_r == 4'h7) begin
            cnt_r <= 4'h8;
            case (state_r)
              ST_ADDR: begin
                // Answers only when ready and selected [RULE_03] [RULE_12] [RULE_13] [RULE_17]
                if (sh_r[7:1] == `DEV_ADDR && ready_o && !sel_s_r[1])
                  sda_oe_o <= 1'b1;
                else
                  state_r <= ST_IDLE;
              end
              ST_PTR: begin
                ptr_r    <= sh_r;
                sda_oe_o <= 1'b1;
              end
              ST_WR: begin
                if (ptr_r == `OFS_MASK) begin
                  mask_wr_pend_r <= 1'b1;
                  mask_wr_val_r  <= sh_r;
                end
                if (ptr_r == `OFS_CONTROL) begin
                  ctrl_wr_pend_r <= 1'b1;
                  ctrl_wr_val_r  <= sh_r;
                end
                ptr_r    <= ptr_r + 8'h01;
                sda_oe_o <= 1'b1;
              end
              default: sda_oe_o <= 1'b0;
            endcase
          end else if (cnt_r == 4'h8) begin
            cnt_r    <= 4'h0;
            sda_oe_o <= 1'b0;
            if ((state_r == ST_ADDR && sh_r[0]) || (state_r == ST_RD && !nack_r)) begin
              state_r  <= ST_RD;
              tx_r     <= rd_data;
              sda_oe_o <= ~rd_data[7];
              ptr_r    <= ptr_r + 8'h01;
              if (ptr_r == `OFS_FLAGS)
                clr_pend_r <= clr_pend_r | flags_r;  // Only bits seen set are cleared [RULE_07]
              if (ptr_r == `OFS_STATUS)
                init_clr_pend_r <= 1'b1;
            end else if (state_r == ST_ADDR) begin
              state_r <= ST_PTR;
            end else if (state_r == ST_PTR) begin
              state_r <= ST_WR;
            end else if (state_r == ST_RD) begin
              state_r <= ST_IDLE;
            end
          end else begin
            cnt_r <= cnt_r + 4'h1;
            if (state_r == ST_RD) begin
              tx_r     <= {tx_r[6:0], 1'b0};
              sda_oe_o <= ~tx_r[6];
            end
          end
        end
      end
    end
  end

endmodule

// ### rtl/module_mgmt_map.vh
// Constants for the module management control block
`ifndef MODULE_MGMT_MAP_VH
`define MODULE_MGMT_MAP_VH

`define CLK_FREQ_KHZ        200000
`define INIT_TIME_MS        2000
`define RESET_MIN_TIME_US   2
`define INIT_CYCLES         (`INIT_TIME_MS * `CLK_FREQ_KHZ)
`define RESET_MIN_CYCLES    ((`RESET_MIN_TIME_US * `CLK_FREQ_KHZ + 999) / 1000)

`define DEV_ADDR            7'h50
`define OFS_IDENT           8'h00
`define OFS_STATUS          8'h02
`define OFS_FLAGS           8'h03
`define OFS_CONTROL         8'h5D
`define OFS_MASK            8'h64

`define STATUS_DNR_BIT      0
`define CTRL_OVERRIDE_BIT   0
`define CTRL_POWER_SET_BIT  1

`define FLAGS_RESET         8'h00
`define MASK_RESET          8'h00
`define CTRL_RESET          8'h00

`endif

// ### test/host_twowire.sv
// Behavioural two-wire bus host
`timescale 1ns/100ps
module host_twowire (
  input  wire sda_i,
  output reg  scl_o,
  output reg  pull_o
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  ////////////////////////////////////////
  // Start or repeated start; releases data, raises the clock, pulls data low, then leaves the clock low
  task start;
    begin
      #8 pull_o = 1'b0;
      #24 scl_o = 1'b1;
      #16 pull_o = 1'b1;
      #16 scl_o = 1'b0;
      #16;
    end
  endtask
  // Eight bits and the acknowledge bit, 64 ns each
  task xfer(input [7:0] d, input mack, output [7:0] r, output ack);
    reg [8:0] sh;
    integer   i;
    begin
      sh = {d, !mack};
      for (i = 0; i < 9; i = i + 1) begin
        #8 pull_o = !sh[8];
        #8 scl_o = 1'b1;
        #16 sh = {sh[7:0], sda_i};
        #16 scl_o = 1'b0;
        #16;
      end
      r = sh[8:1];
      ack = sh[0];
    end
  endtask
  task stop;
    begin
      #8 pull_o = 1'b1;
      #24 scl_o = 1'b1;
      #16 pull_o = 1'b0;
      #32;
    end
  endtask
endmodule

// ### test/module_mgmt_control_timing_assertions.sv
// Concurrent checks on the module management control block ports
`timescale 1ns/100ps
module mgmt_checker #(
  parameter [31:0] INIT_CYCLES = 200
) (
  input wire       ref_clk_i,
  input wire       reset_n_i,
  input wire       module_reset_n_i,
  input wire       module_select_n_i,
  input wire       low_power_request_pin_i,
  input wire [7:0] flag_condition_i,
  input logic      sda_oe_o,
  input logic      interrupt_out_n_o,
  input logic      low_power_o,
  input logic      ready_o
);
  reg [10:0] rst_cnt_r;
  reg [31:0] wait_cnt_r;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Reset pin low time and wait for readiness
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_cnt_r  <= 11'h000;
      wait_cnt_r <= 32'h0000_0000;
    end else begin
      rst_cnt_r  <= module_reset_n_i ? 11'h000 : rst_cnt_r + 11'h001;
      wait_cnt_r <= (ready_o || !module_reset_n_i) ? 32'h0000_0000 : wait_cnt_r + 32'h0000_0001;
    end
  end
  ////////////////////////////////////////
  sequence s_ready_up; $rose(ready_o); endsequence
  sequence s_int_low; ##[1:3] !interrupt_out_n_o; endsequence
  a_init_bound: assert property (wait_cnt_r <= INIT_CYCLES + 32'h0000_0010) else $error("ready late");
  a_ready_int: assert property (s_ready_up |-> s_int_low) else $error("no ready interrupt");
  a_no_answer: assert property (!ready_o |-> !sda_oe_o) else $error("answer before ready");
  a_quiet_unready: assert property (!ready_o [*3] |-> interrupt_out_n_o) else $error("early interrupt");
  a_loss_int: assert property ($rose(|flag_condition_i[3:1]) && ready_o |-> s_int_low)
    else $error("loss interrupt late");
  a_flag_int: assert property ($rose(|flag_condition_i[7:4]) && ready_o |-> s_int_low)
    else $error("flag interrupt late");
  a_lp_pin: assert property ($rose(low_power_request_pin_i) |-> ##[1:4] low_power_o)
    else $error("low power late");
  a_desel_quiet: assert property (module_select_n_i [*8] |-> !sda_oe_o) else $error("answer unselected");
  a_long_reset: assert property (rst_cnt_r == 11'h1A4 |-> !ready_o) else $error("reset missed");
  a_short_ignored: assert property ($fell(ready_o) |-> rst_cnt_r >= 11'h190) else $error("short reset");
endmodule

bind module_mgmt_control_timing mgmt_checker #(.INIT_CYCLES(INIT_CYCLES)) u_mgmt_checker (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .module_reset_n_i(module_reset_n_i),
  .module_select_n_i(module_select_n_i), .low_power_request_pin_i(low_power_request_pin_i),
  .flag_condition_i(flag_condition_i), .sda_oe_o(sda_oe_o), .interrupt_out_n_o(interrupt_out_n_o),
  .low_power_o(low_power_o), .ready_o(ready_o)
);

// ### test/tb.sv
// Bench of the module management control block
`timescale 1ns/100ps
module tb;
  reg        clk, rst_n, a;
  reg  [2:0] pins;
  reg  [7:0] flags, v;
  wire       scl, pull, oe, sda_out, int_n, low_pwr, ready, sda_w;
  wire [2:0] st;
  integer    err_count, n_checks, cyc;
  assign sda_w = !(pull || (oe && !sda_out));
  assign st = {ready, low_pwr, int_n};
  // Identifier value is arbitrary
  module_mgmt_control_timing #(.INIT_CYCLES(32'h0000_00C8), .IDENT_VALUE(8'h3C)) DUT (
    .ref_clk_i(clk), .reset_n_i(rst_n), .module_reset_n_i(pins[2]), .module_select_n_i(pins[0]),
    .low_power_request_pin_i(pins[1]), .flag_condition_i(flags), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_out), .sda_oe_o(oe), .interrupt_out_n_o(int_n), .low_power_o(low_pwr), .ready_o(ready));
  host_twowire u_host (.sda_i(sda_w), .scl_o(scl), .pull_o(pull));
  always #2.5 clk = !clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      print_verdict;
    end
  end
  ////////////////////////////////////////
  task check(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task look(input integer n, input integer idx, input e);
    begin
      repeat (n) @(negedge clk);
      check({7'h00, st[idx]}, {7'h00, e});
    end
  endtask
  task drv(input [2:0] p, input [7:0] f);
    begin
      @(posedge clk);
      pins <= p;
      flags <= f;
      @(posedge clk);
      flags <= 8'h00;
    end
  endtask
  task rdy;
    integer k;
    begin
      for (k = 0; k < 400 && ready !== 1'b1; k = k + 1) @(negedge clk);
      look(0, 2, 1'b1);
    end
  endtask
  // Kind 0 address only, 1 write, 2 read back under mask d
  task bus(input [7:0] adr, input [7:0] ptr, input [7:0] d, input [1:0] n, input [7:0] e);
    begin
      @(negedge clk);  // Keeps host edges off the sampling edge
      u_host.start;
      u_host.xfer(adr, 1'b0, v, a);
      if (n != 2'h0) u_host.xfer(ptr, 1'b0, v, a);
      if (n == 2'h1) u_host.xfer(d, 1'b0, v, a);
      if (n == 2'h2) begin
        u_host.start;
        u_host.xfer(8'hA1, 1'b0, v, a);
        u_host.xfer(8'hFF, 1'b0, v, a);
      end
      u_host.stop;
      check((n == 2'h2) ? (v & d) : {7'h00, a}, e);
    end
  endtask
  task print_verdict;
    begin
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    pins = 3'h4;
    flags = 8'h00;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bus(8'hA0, 8'h00, 8'h00, 2'h0, 8'h01);
    rdy;
    look(3, 0, 1'b0);
    bus(8'hA0, 8'h02, 8'h01, 2'h2, 8'h00);
    look(6, 0, 1'b1);
    bus(8'hA2, 8'h00, 8'h00, 2'h0, 8'h01);
    drv(3'h4, 8'h12);
    look(3, 0, 1'b0);
    bus(8'hA0, 8'h03, 8'hFF, 2'h2, 8'h12);
    look(6, 0, 1'b1);
    bus(8'hA0, 8'h64, 8'h01, 2'h1, 8'h00);
    drv(3'h4, 8'h01);
    look(3, 0, 1'b1);
    bus(8'hA0, 8'h64, 8'h00, 2'h1, 8'h00);
    look(6, 0, 1'b0);
    bus(8'hA0, 8'h03, 8'hFF, 2'h2, 8'h01);
    drv(3'h5, 8'h00);
    bus(8'hA0, 8'h00, 8'h00, 2'h0, 8'h01);
    drv(3'h4, 8'h00);
    bus(8'hA0, 8'h00, 8'hFF, 2'h2, 8'h3C);
    drv(3'h6, 8'h00);
    look(4, 1, 1'b1);
    drv(3'h4, 8'h00);
    bus(8'hA0, 8'h5D, 8'h03, 2'h1, 8'h00);
    look(6, 1, 1'b1);
    bus(8'hA0, 8'h5D, 8'h00, 2'h1, 8'h00);
    look(6, 1, 1'b0);
    drv(3'h0, 8'h00);
    repeat (100) @(negedge clk);
    drv(3'h4, 8'h00);
    look(4, 2, 1'b1);
    drv(3'h0, 8'h00);
    look(450, 2, 1'b0);
    drv(3'h4, 8'h00);
    rdy;
    print_verdict;
  end
endmodule
